// [bench/dsmr_feed.sv]
module dsmr_feed(input wire logic pclk,s_i,l_i,input wire logic [3:0] a_i,b_i,
	output logic s,l,output logic [3:0] a,b);
timeunit 1ns;timeprecision 1ns;
// Words and controls launched at an edge, stable across the next one
initial {s,l,a,b}=10'h100;
always @(posedge pclk) {s,l,a,b}<={s_i,l_i,a_i,b_i};
endmodule

// [bench/dsmr_properties.sv]
module dsmr_chk(input wire logic pclk,presetn,clk_en,src_select,load_en_n,force_zero_n,
	input wire logic [3:0] first_source_bit,second_source_bit,true_out,comp_out);
timeunit 1ns;timeprecision 1ns;
default clocking @(posedge pclk);endclocking
default disable iff(!presetn);
a_comp_inv:assert property(comp_out==~true_out)else $error("comp");
a_load_first:assert property(clk_en&&force_zero_n&&!load_en_n&&!src_select
	|=>true_out==$past(first_source_bit))else $error("ld a");
a_load_second:assert property(clk_en&&force_zero_n&&!load_en_n&&src_select
	|=>true_out==$past(second_source_bit))else $error("ld b");
a_hold_n:assert property(clk_en&&load_en_n&&force_zero_n|=>!force_zero_n||$stable(true_out))else $error("hold");
a_freeze_all:assert property(!clk_en&&force_zero_n|=>!force_zero_n||$stable(true_out))else $error("freeze");
a_load_gate:assert property($changed(true_out)&&force_zero_n&&$past(force_zero_n)
	|->$past(!load_en_n))else $error("gate");
a_clear_true:assert property(!force_zero_n|->true_out==4'h0)else $error("clr");
a_clear_comp:assert property(!force_zero_n|->comp_out==4'hF)else $error("clr c");
c_a:cover property(!src_select&&!load_en_n);
c_b:cover property(src_select&&!load_en_n);
c_clr:cover property(!force_zero_n);
endmodule
bind dsmr_top dsmr_chk i_dsmr_chk(.*);

// [bench/dsmr_top_tb.sv]
module dsmr_top_tb;
timeunit 1ns;timeprecision 100ps;
logic pclk=0,presetn=0,clk_en=1,force_zero_n=1,psel=0,penable=0,pwrite=0,s=0,l=1,sl,ll,pready,pslverr,er;
logic [3:0] a=0,b=0,al,bl,t,c;
logic [11:0] paddr=0;
logic [31:0] pwdata=0,prdata,rd;
int mismatches=0,total_checks=0,cyc=0;
always #12.5 pclk=~pclk;
dsmr_feed i_dsmr_feed(.pclk,.s_i(s),.l_i(l),.a_i(a),.b_i(b),.s(sl),.l(ll),.a(al),.b(bl));
dsmr_top i_dsmr_top(.pclk,.presetn,.clk_en,.first_source_bit(al),.second_source_bit(bl),.src_select(sl),
	.load_en_n(ll),.force_zero_n,.true_out(t),.comp_out(c),.psel,.penable,.pwrite,.paddr,.pwdata,.prdata,
	.pready,.pslverr);
task chk(input logic [32:0] g,e);
	total_checks++;
	if(g!==e) begin
		mismatches++;
		$display("mismatch %0t got %h exp %h",$time,g,e);
	end
endtask
task results;
	if(mismatches==0&&total_checks>0) $display("DONE - PASS");
	else $display("DONE - FAIL");
	$finish;
endtask
// APB read: setup, access until pready
task rdw(input logic [11:0] ad);
	psel<=1;
	paddr<=ad;
	@(posedge pclk) penable<=1;
	do @(posedge pclk); while(pready!==1'b1);
	{er,rd}={pslverr,prdata};
	psel<=0;
	penable<=0;
	@(posedge pclk);
endtask
// APB write: setup, access until pready
task wrw(input logic [11:0] ad,input logic [31:0] wd);
	psel<=1;
	pwrite<=1;
	paddr<=ad;
	pwdata<=wd;
	@(posedge pclk) penable<=1;
	do @(posedge pclk); while(pready!==1'b1);
	er=pslverr;
	psel<=0;
	penable<=0;
	pwrite<=0;
	@(posedge pclk);
endtask
// Present words, wait for the load, check both polarities
task ld(input logic sv,lv,input logic [3:0] av,bv,e);
	{s,l,a,b}<={sv,lv,av,bv};
	repeat(3) @(posedge pclk);
	@(negedge pclk) chk({c,t},{~e,e});
	@(posedge pclk);
endtask
always @(posedge pclk) if(++cyc>500) begin
	mismatches++;
	results;
end
initial begin
	repeat(16) @(posedge pclk);
	presetn<=1;
	ld(0,0,4'h5,4'hA,4'h5);
	ld(1,0,4'h3,4'hC,4'hC);
	clk_en<=0;
	ld(0,0,4'h9,4'h9,4'hC);
	ld(1,1,4'h6,4'h6,4'hC);
	clk_en<=1;
	ld(0,1,4'h6,4'h6,4'hC);
	force_zero_n<=0;
	@(negedge pclk) chk({c,t},8'hF0);
	@(posedge pclk) force_zero_n<=1;
	rdw(12'h004);
	chk({er,rd},33'h0_0000_00F0);
	rdw(12'h000);
	chk({er,rd},33'h0_0000_000A);
	rdw(12'h010);
	chk({er,rd},33'h1_0000_0000);
	wrw(12'h008,32'h0000_0005);
	rdw(12'h008);
	chk({er,rd},33'h0_0000_0005);
	wrw(12'h010,32'h0000_0003);
	chk(er,1'b1);
	results;
end
endmodule

// [src/dsmr_params.svh]
`ifndef DSMR_PARAMS_SVH
`define DSMR_PARAMS_SVH
// Register width and reset image
`define DSMR_WIDTH 4
`define DSMR_RESET_TRUE 4'h0
// APB register byte offsets
`define DSMR_OFF_CTRL 12'h000
`define DSMR_OFF_STAT 12'h004
`define DSMR_OFF_SRCA 12'h008
`define DSMR_OFF_SRCB 12'h00C
// Control register field positions
`define DSMR_CTRL_SELECT 0
`define DSMR_CTRL_HOLD_N 1
`define DSMR_CTRL_ENAVAR 2
`define DSMR_CTRL_CLEAR_N 3
`define DSMR_CTRL_LOAD 4
// Control register reset value: clear released, load disabled
`define DSMR_CTRL_RESET 5'h0A
`endif

// [src/dsmr_pkg.sv]
package dsmr_pkg;
	typedef logic [3:0] dsmr_word_type;
	typedef struct packed {
		logic [4:0] ctrl_q;
		dsmr_word_type srca_q;
		dsmr_word_type srcb_q;
		logic [31:0] prdata_q;
	} dsmr_state_type;
endpackage

// [src/dsmr_top.sv]
// Decided for this implementation: the register offsets and register access over APB.
`include "dsmr_params.svh"

module dsmr_top (
	// Clock, reset, clock enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Data words and controls from the datapath
	input wire logic [3:0] first_source_bit,
	input wire logic [3:0] second_source_bit,
	input wire logic src_select,
	input wire logic load_en_n,
	input wire logic force_zero_n,
	// Stored outputs
	output logic [3:0] true_out,
	output logic [3:0] comp_out,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	// Register-side state; the stored word is kept apart
	dsmr_pkg::dsmr_state_type state_q;
	dsmr_pkg::dsmr_state_type state_d;
	dsmr_pkg::dsmr_word_type true_q;
	dsmr_pkg::dsmr_word_type true_d;

	// Bus phases and address decode
	logic apb_setup;
	logic apb_access;
	logic apb_wr;
	logic apb_rd;
	logic hit_ctrl;
	logic hit_stat;
	logic hit_srca;
	logic hit_srcb;
	logic mapped;

	// Write strobes
	logic wr_ctrl;
	logic wr_srca;
	logic wr_srcb;

	// Control fields and software load pulse
	logic ctrl_select;
	logic ctrl_hold_n;
	logic ctrl_clear_n;
	logic soft_mode;
	logic load_pulse;
	logic pulse_sel;
	dsmr_pkg::dsmr_word_type soft_word;

	// Effective sources and controls
	logic sel_eff;
	logic hold_n_eff;
	logic clear_n_eff;
	logic true_rst_n;
	dsmr_pkg::dsmr_word_type word_a;
	dsmr_pkg::dsmr_word_type word_b;
	dsmr_pkg::dsmr_word_type picked;

	// Two-way mux per bit; one select steers every bit
	function automatic dsmr_pkg::dsmr_word_type pick(
		input logic s,
		input dsmr_pkg::dsmr_word_type a,
		input dsmr_pkg::dsmr_word_type b
	);
		dsmr_pkg::dsmr_word_type w;
		w = a;
		for (int i = 0; i < `DSMR_WIDTH; i++) begin
			if (s) begin
				w[i] = b[i];
			end else begin
				w[i] = a[i];
			end
		end
		pick = w;
	endfunction

	// One address match against a register offset
	function automatic logic addr_hit(
		input logic [11:0] a,
		input logic [11:0] off
	);
		addr_hit = (a == off);
	endfunction

	// Low nibble of a bus word, as a source register holds it
	function automatic dsmr_pkg::dsmr_word_type src_image(
		input logic [31:0] w
	);
		src_image = w[3:0];
	endfunction

	// Control write image; the load bit is a pulse, never stored
	function automatic logic [4:0] ctrl_image(
		input logic [31:0] w
	);
		ctrl_image = {1'b0, w[3:0]};
	endfunction

	// Zero-extend a four-bit word onto the bus
	function automatic logic [31:0] widen4(
		input dsmr_pkg::dsmr_word_type w
	);
		widen4 = {28'h000_0000, w};
	endfunction

	// Status image: true bits low, complement bits above them
	function automatic logic [31:0] status_image(
		input dsmr_pkg::dsmr_word_type w
	);
		status_image = {24'h00_0000, ~w, w};
	endfunction

	// Read multiplexer; unmapped addresses read zero
	function automatic logic [31:0] read_word(
		input logic [11:0] a,
		input logic [4:0] ctrl,
		input dsmr_pkg::dsmr_word_type sa,
		input dsmr_pkg::dsmr_word_type sb,
		input dsmr_pkg::dsmr_word_type tw
	);
		logic [31:0] r;

		case (a)
			`DSMR_OFF_CTRL: begin
				r = {27'h000_0000, ctrl};
			end
			`DSMR_OFF_STAT: begin
				r = status_image(tw);
			end
			`DSMR_OFF_SRCA: begin
				r = widen4(sa);
			end
			`DSMR_OFF_SRCB: begin
				r = widen4(sb);
			end
			default: begin
				r = 32'h0000_0000;
			end
		endcase
		read_word = r;
	endfunction

	// Priority for the stored word: clear, then pulse, then load of the picked word
	function automatic dsmr_pkg::dsmr_word_type next_word(
		input dsmr_pkg::dsmr_word_type cur,
		input logic hold_n,
		input dsmr_pkg::dsmr_word_type pin_word,
		input logic pulse,
		input dsmr_pkg::dsmr_word_type pulse_word,
		input logic clear_n
	);
		dsmr_pkg::dsmr_word_type n;
		// Load only while the active-low enable is low
		if (!hold_n) begin
			n = pin_word;
		end else begin
			n = cur;
		end
		// Software pulse loads from the source registers
		if (pulse) begin
			n = pulse_word;
		end
		// Clear wins over any load
		if (!clear_n) begin
			n = `DSMR_RESET_TRUE;
		end
		next_word = n;
	endfunction

	// Bus phases; every access ends at once
	assign apb_setup = psel && !penable;
	assign apb_access = psel && penable;
	assign apb_wr = apb_access && pwrite;
	assign apb_rd = apb_setup && !pwrite;
	assign pready = 1'b1;

	// Address decode and error response
	assign hit_ctrl = addr_hit(paddr, `DSMR_OFF_CTRL);
	assign hit_stat = addr_hit(paddr, `DSMR_OFF_STAT);
	assign hit_srca = addr_hit(paddr, `DSMR_OFF_SRCA);
	assign hit_srcb = addr_hit(paddr, `DSMR_OFF_SRCB);
	assign mapped = hit_ctrl || hit_stat || hit_srca || hit_srcb;
	assign pslverr = apb_access && !mapped;

	// Write strobes at the access edge
	assign wr_ctrl = apb_wr && hit_ctrl;
	assign wr_srca = apb_wr && hit_srca;
	assign wr_srcb = apb_wr && hit_srcb;

	// Stored control fields
	assign ctrl_select = state_q.ctrl_q[`DSMR_CTRL_SELECT];
	assign ctrl_hold_n = state_q.ctrl_q[`DSMR_CTRL_HOLD_N];
	assign ctrl_clear_n = state_q.ctrl_q[`DSMR_CTRL_CLEAR_N];
	assign soft_mode = state_q.ctrl_q[`DSMR_CTRL_ENAVAR];

	// Software load pulse; its select rides in the same write
	assign load_pulse = wr_ctrl && pwdata[`DSMR_CTRL_LOAD];
	assign pulse_sel = pwdata[`DSMR_CTRL_SELECT];
	assign soft_word = pick(pulse_sel, state_q.srca_q, state_q.srcb_q);

	// Pin clear and software clear combined
	assign clear_n_eff = force_zero_n && ctrl_clear_n;

	// Pins or software registers feed the muxes
	always_comb begin
		if (soft_mode) begin
			sel_eff = ctrl_select;
			word_a = state_q.srca_q;
			word_b = state_q.srcb_q;
			hold_n_eff = ctrl_hold_n;
		end else begin
			sel_eff = src_select;
			word_a = first_source_bit;
			word_b = second_source_bit;
			hold_n_eff = load_en_n;
		end
	end

	// Word seen at every flip-flop input
	assign picked = pick(sel_eff, word_a, word_b);

	// Reset or the clear pin empties the word without the clock
	assign true_rst_n = presetn && force_zero_n;

	// Next-state logic
	always_comb begin
		state_d = state_q;
		// Stored word
		true_d = next_word(
			true_q,
			hold_n_eff,
			picked,
			load_pulse,
			soft_word,
			clear_n_eff
		);
		// Register writes
		if (wr_ctrl) begin
			state_d.ctrl_q = ctrl_image(pwdata);
		end
		if (wr_srca) begin
			state_d.srca_q = src_image(pwdata);
		end
		if (wr_srcb) begin
			state_d.srcb_q = src_image(pwdata);
		end
		// Read data captured in setup, shown in access
		if (apb_rd) begin
			state_d.prdata_q = read_word(
				paddr,
				state_q.ctrl_q,
				state_q.srca_q,
				state_q.srcb_q,
				true_q
			);
		end
	end

	// Register-side state; frozen while clock enable is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q.ctrl_q <= `DSMR_CTRL_RESET;
			state_q.srca_q <= 4'h0;
			state_q.srcb_q <= 4'h0;
			state_q.prdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			state_q.ctrl_q <= state_d.ctrl_q;
			state_q.srca_q <= state_d.srca_q;
			state_q.srcb_q <= state_d.srcb_q;
			state_q.prdata_q <= state_d.prdata_q;
		end
	end

	// Stored word apart, so the clear pin acts without the clock
	always_ff @(posedge pclk or negedge true_rst_n) begin
		if (!true_rst_n) begin
			true_q <= `DSMR_RESET_TRUE;
		end else if (clk_en) begin
			true_q <= true_d;
		end
	end

	// Outputs
	assign true_out = true_q;
	assign comp_out = ~true_q;
	assign prdata = state_q.prdata_q;
endmodule
